// >>> core/atp_pkg.sv
// Constants and carrier types for the ASCII read-all command parser
package atp_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int REPLY_LIMIT_MS = 100;
  localparam int REPLY_LIMIT_CYC = (CLK_HZ / 1000) * REPLY_LIMIT_MS;
  localparam int FRAME_DATA_BITS = 8;
  localparam int STRAP_SETTLE = 3;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] ADDR_SHIPPED = 8'h01;
  localparam logic [7:0] ADDR_FORCED = 8'h00;
  localparam logic [7:0] CHAN_EN_RST = 8'hff;
  localparam int NUM_CH = 8;
  localparam int VAL_W = 17;
  localparam logic [16:0] VAL_MAX = 17'h1869f;
  localparam logic [5:0] DATA_LEN = 6'h3a;
  localparam logic [5:0] ERR_LEN = 6'h04;
  localparam logic [2:0] FIELD_LAST = 3'h6;
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_CHEN = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int STAT_FORCED_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_ADDR_LSB = 8;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } atp_bus_req_t;

  typedef logic [NUM_CH-1:0][VAL_W-1:0] atp_chan_vals_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b10,
    SER_STOP = 2'b11
  } atp_ser_state_t;

  typedef enum logic [1:0] {
    REP_NONE = 2'b00,
    REP_DATA = 2'b01,
    REP_ERR = 2'b10
  } atp_rep_kind_t;
endpackage

// >>> core/atp_parser.sv
// Serial read-all command parser with formatted reply transmitter
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module atp_parser
  import atp_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial line and transceiver
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_drive,
  // Default-configuration switch, high in forcing position
  input wire logic default_force,
  // Register port
  input wire atp_bus_req_t bus_req,
  output logic [31:0] rd_data,
  // Engineering-unit channel values, hundredths, scaled upstream
  input wire atp_chan_vals_t chan_vals
);

  // Counters are 16 bits wide and the receiver needs a half-bit point
  if (BIT_CYCLES_P < 4 || BIT_CYCLES_P > 65535) begin : g_bad_bit_cycles
    $error("BIT_CYCLES_P out of range");
  end

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES_P - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES_P / 2);

  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_q <= 2'b00;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    // Upper-case digits only; lower case is malformed
    if (c >= CH_ZERO && c < 8'h3a) return {1'b1, 4'(c - CH_ZERO)};
    if (c >= CH_A && c < 8'h47) return {1'b1, 4'(c - CH_A + 8'h0a)};
    return 5'h00;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < 4'ha) return CH_ZERO + {4'h0, n};
    return CH_A + {4'h0, n} - 8'h0a;
  endfunction

  function automatic logic [19:0] to_bcd(input logic [16:0] b);
    logic [36:0] s;
    integer i;
    integer d;
    s = {20'h00000, b};
    for (i = 0; i < 17; i++) begin
      for (d = 0; d < 5; d++) begin
        if (s[17+4*d +: 4] > 4'h4) s[17+4*d +: 4] = s[17+4*d +: 4] + 4'h3;
      end
      s = s << 1;
    end
    return s[36:17];
  endfunction

  // Strap capture: the switch is only honoured once, just after each reset
  logic [2:0] force_sync_q;
  logic [1:0] strap_cnt_q;
  logic strap_done_q;
  logic forced_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      force_sync_q <= 3'b000;
      strap_cnt_q <= 2'b00;
      strap_done_q <= 1'b0;
      forced_q <= 1'b0;
    end else begin
      force_sync_q <= {force_sync_q[1:0], default_force};
      if (!strap_done_q) begin
        if (strap_cnt_q != 2'(STRAP_SETTLE)) begin
          strap_cnt_q <= strap_cnt_q + 2'b01;
        end else if (force_sync_q[1] == force_sync_q[2]) begin
          forced_q <= force_sync_q[2];
          strap_done_q <= 1'b1;
        end
      end
    end
  end

  // Register port
  logic [7:0] addr_cfg_q;
  logic [7:0] chan_en_q;
  logic [7:0] eff_addr;
  atp_rep_kind_t rep_kind_q;
  logic [31:0] rd_data_q;
  assign eff_addr = forced_q ? ADDR_FORCED : addr_cfg_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_cfg_q <= ADDR_SHIPPED;
      chan_en_q <= CHAN_EN_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == REG_ADDR) addr_cfg_q <= bus_req.wdata[7:0];
      if (bus_req.addr == REG_CHEN) chan_en_q <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 32'h00000000;
    end else if (bus_req.rd) begin
      rd_data_q <= 32'h00000000;
      case (bus_req.addr)
        REG_ADDR: rd_data_q[7:0] <= addr_cfg_q;
        REG_CHEN: rd_data_q[7:0] <= chan_en_q;
        REG_STAT: begin
          rd_data_q[STAT_FORCED_BIT] <= forced_q;
          rd_data_q[STAT_BUSY_BIT] <= rep_kind_q != REP_NONE;
          rd_data_q[STAT_ADDR_LSB +: 8] <= eff_addr;
        end
        default: rd_data_q <= 32'h00000000;
      endcase
    end else begin
      rd_data_q <= 32'h00000000;
    end
  end
  assign rd_data = rd_data_q;

  // Receive path; a change counts once the second and third stages agree
  logic [2:0] rx_sync_q;
  logic rx_lvl_q;
  atp_ser_state_t rx_state_q;
  logic [15:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sr_q;
  logic rx_done_q;
  logic rx_ferr_q;
  logic [7:0] rx_byte_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_q <= 3'b111;
      rx_lvl_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin};
      if (rx_sync_q[1] == rx_sync_q[2]) rx_lvl_q <= rx_sync_q[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= SER_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 3'h0;
      rx_sr_q <= 8'h00;
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      rx_done_q <= 1'b0;
      case (rx_state_q)
        SER_IDLE: begin
          if (!rx_lvl_q) begin
            rx_state_q <= SER_START;
            rx_cnt_q <= BIT_HALF;
          end
        end
        SER_START: begin
          if (rx_cnt_q != 16'h0000) rx_cnt_q <= rx_cnt_q - 16'h0001;
          else if (rx_lvl_q) rx_state_q <= SER_IDLE;
          else begin
            rx_state_q <= SER_DATA;
            rx_cnt_q <= BIT_LAST;
            rx_bit_q <= 3'h0;
          end
        end
        SER_DATA: begin
          if (rx_cnt_q != 16'h0000) rx_cnt_q <= rx_cnt_q - 16'h0001;
          else begin
            rx_sr_q <= {rx_lvl_q, rx_sr_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            rx_cnt_q <= BIT_LAST;
            if (rx_bit_q == 3'(FRAME_DATA_BITS - 1)) rx_state_q <= SER_STOP;
          end
        end
        SER_STOP: begin
          if (rx_cnt_q != 16'h0000) rx_cnt_q <= rx_cnt_q - 16'h0001;
          else begin
            rx_done_q <= 1'b1;
            rx_ferr_q <= !rx_lvl_q;
            rx_byte_q <= rx_sr_q;
            rx_state_q <= SER_IDLE;
          end
        end
        default: rx_state_q <= SER_IDLE;
      endcase
    end
  end

  // Command collection
  logic collecting_q;
  logic [7:0] prefix_q;
  logic [1:0] ccount_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic rx_good;
  logic is_prefix;
  logic cmd_end;
  logic addr_match;
  logic go_data;
  logic go_err;
  logic [4:0] hv;
  logic [4:0] lv;
  assign rx_good = rx_done_q && !rx_ferr_q;
  assign is_prefix = rx_byte_q == CH_HASH || rx_byte_q == CH_DOLLAR ||
                     rx_byte_q == CH_PCT;
  assign hv = hex_val(hi_q);
  assign lv = hex_val(lo_q);
  assign addr_match = hv[4] && lv[4] && {hv[3:0], lv[3:0]} == eff_addr;
  // Replies are dropped until the reply going out has handed its last character to the transmitter
  assign cmd_end = rx_good && collecting_q && rx_byte_q == CH_CR &&
                   ccount_q >= 2'd2 && rep_kind_q == REP_NONE;
  assign go_data = cmd_end && addr_match && prefix_q == CH_HASH &&
                   ccount_q == 2'd2;
  assign go_err = cmd_end && addr_match && !go_data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      collecting_q <= 1'b0;
      prefix_q <= 8'h00;
      ccount_q <= 2'd0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (rx_done_q) begin
      if (rx_ferr_q) begin
        collecting_q <= 1'b0;
      end else if (is_prefix) begin
        collecting_q <= 1'b1;
        prefix_q <= rx_byte_q;
        ccount_q <= 2'd0;
      end else if (collecting_q) begin
        if (rx_byte_q == CH_CR) collecting_q <= 1'b0;
        else begin
          if (ccount_q == 2'd0) hi_q <= rx_byte_q;
          if (ccount_q == 2'd1) lo_q <= rx_byte_q;
          if (ccount_q != 2'd3) ccount_q <= ccount_q + 2'd1;
        end
      end
    end
  end

  // Reply sequencer
  logic [5:0] idx_q;
  logic [2:0] ch_q;
  logic [2:0] pos_q;
  atp_chan_vals_t vals_q;
  logic [7:0] en_q;
  atp_ser_state_t tx_state_q;
  logic tx_take;
  logic [7:0] tx_char;
  logic [16:0] cur_val;
  logic [16:0] mag;
  logic [19:0] bcd;
  assign tx_take = tx_state_q == SER_IDLE && rep_kind_q != REP_NONE;
  assign cur_val = vals_q[ch_q];
  assign mag = cur_val[16] ? 17'(-cur_val) : cur_val;
  assign bcd = to_bcd(mag > VAL_MAX ? VAL_MAX : mag);

  always_comb begin
    tx_char = CH_CR;
    if (rep_kind_q == REP_ERR) begin
      case (idx_q)
        6'd0: tx_char = CH_QM;
        6'd1: tx_char = hex_char(eff_addr[7:4]);
        6'd2: tx_char = hex_char(eff_addr[3:0]);
        default: tx_char = CH_CR;
      endcase
    end else if (idx_q == 6'd0) begin
      tx_char = CH_GT;
    end else if (idx_q != DATA_LEN - 6'd1) begin
      if (!en_q[ch_q]) tx_char = CH_SP;
      else begin
        case (pos_q)
          3'd0: tx_char = cur_val[16] ? CH_MINUS : CH_PLUS;
          3'd1: tx_char = CH_ZERO + {4'h0, bcd[19:16]};
          3'd2: tx_char = CH_ZERO + {4'h0, bcd[15:12]};
          3'd3: tx_char = CH_ZERO + {4'h0, bcd[11:8]};
          3'd4: tx_char = CH_DOT;
          3'd5: tx_char = CH_ZERO + {4'h0, bcd[7:4]};
          default: tx_char = CH_ZERO + {4'h0, bcd[3:0]};
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_kind_q <= REP_NONE;
      idx_q <= 6'd0;
      ch_q <= 3'd0;
      pos_q <= 3'd0;
      vals_q <= '0;
      en_q <= 8'h00;
    end else if (go_data || go_err) begin
      rep_kind_q <= go_data ? REP_DATA : REP_ERR;
      idx_q <= 6'd0;
      ch_q <= 3'd0;
      pos_q <= 3'd0;
      vals_q <= chan_vals;
      en_q <= chan_en_q;
    end else if (tx_take) begin
      idx_q <= idx_q + 6'd1;
      if (idx_q != 6'd0 && rep_kind_q == REP_DATA) begin
        pos_q <= pos_q == FIELD_LAST ? 3'd0 : pos_q + 3'd1;
        if (pos_q == FIELD_LAST) ch_q <= ch_q + 3'd1;
      end
      if (idx_q == (rep_kind_q == REP_ERR ? ERR_LEN : DATA_LEN) - 6'd1) begin
        rep_kind_q <= REP_NONE;
      end
    end
  end

  // Transmit path, 8N1
  logic [15:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sr_q;
  logic tx_pin_q;
  logic tx_drive_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= SER_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 3'h0;
      tx_sr_q <= 8'h00;
      tx_pin_q <= 1'b1;
      tx_drive_q <= 1'b0;
    end else begin
      tx_drive_q <= tx_take || tx_state_q != SER_IDLE ||
                    rep_kind_q != REP_NONE;
      if (tx_take) begin
        tx_sr_q <= tx_char;
        tx_pin_q <= 1'b0;
        tx_cnt_q <= BIT_LAST;
        tx_state_q <= SER_START;
      end else if (tx_state_q != SER_IDLE) begin
        if (tx_cnt_q != 16'h0000) tx_cnt_q <= tx_cnt_q - 16'h0001;
        else begin
          tx_cnt_q <= BIT_LAST;
          case (tx_state_q)
            SER_START: begin
              tx_pin_q <= tx_sr_q[0];
              tx_bit_q <= 3'h0;
              tx_state_q <= SER_DATA;
            end
            SER_DATA: begin
              tx_bit_q <= tx_bit_q + 3'h1;
              tx_sr_q <= {1'b0, tx_sr_q[7:1]};
              if (tx_bit_q == 3'(FRAME_DATA_BITS - 1)) begin
                tx_pin_q <= 1'b1;
                tx_state_q <= SER_STOP;
              end else begin
                tx_pin_q <= tx_sr_q[1];
              end
            end
            default: tx_state_q <= SER_IDLE;
          endcase
        end
      end
    end
  end
  assign tx_pin = tx_pin_q;
  assign tx_drive = tx_drive_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_SHIP_ADDR: assert property ($rose(strap_done_q) && !forced_q |->
    eff_addr == ADDR_SHIPPED) else $error("shipped address not 01");
  AST_FORCED: assert property (forced_q |-> eff_addr == ADDR_FORCED)
    else $error("forced mode address not 00");
  AST_DATA_HEAD: assert property (go_data |=> tx_take && tx_char == CH_GT ##1
    !tx_pin_q) else $error("read reply does not start with >");
  AST_ERR_HEAD: assert property (go_err |=> tx_take && tx_char == CH_QM)
    else $error("error reply does not start with ?");
  AST_SILENT: assert property (cmd_end && !addr_match |=>
    rep_kind_q == REP_NONE [*3]) else $error("reply to foreign address");
  AST_SPACE: assert property (tx_take && rep_kind_q == REP_DATA &&
    idx_q != 6'd0 && idx_q != DATA_LEN - 6'd1 && !en_q[ch_q] |->
    tx_char == CH_SP) else $error("disabled channel not blanked");
  AST_CH_ORDER: assert property (tx_take && rep_kind_q == REP_DATA &&
    idx_q != 6'd0 && pos_q == FIELD_LAST |=> ch_q == $past(ch_q) + 3'd1)
    else $error("channel order broken");
  AST_EXEC: assert property (go_data |=> rep_kind_q == REP_DATA &&
    en_q == $past(chan_en_q)) else $error("own command not executed");
  AST_START_BIT: assert property (tx_take |=> !tx_pin_q && tx_drive_q
    && tx_state_q == SER_START) else $error("start bit missing");
  AST_RESP_TIME: assert property ((go_data || go_err) |-> ##2 !tx_pin_q)
    else $error("reply late");
  AST_RESTART: assert property (rx_good && is_prefix |=> collecting_q &&
    ccount_q == 2'd0) else $error("prefix did not restart");
  AST_CR_END: assert property (rx_good && rx_byte_q == CH_CR |=>
    !collecting_q) else $error("carriage return did not end command");

  COV_DATA: cover property (go_data ##1 rep_kind_q == REP_DATA);
  COV_ERR: cover property (go_err);
  COV_FORCED: cover property ($rose(strap_done_q) && forced_q);
endmodule // atp_parser
`default_nettype wire

// >>> tb/atp_host_model.sv
// Host model: sends commands on the serial line and collects replies
`timescale 1ns/1ps
`default_nettype none
module atp_host_model #(
  parameter int BIT_P = 16
) (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic tx_pin,
  input wire logic tx_drive,
  output logic rx_pin
);
  logic [7:0] rx_q[$];
  int frame_errs;

  // Line is biased high while the host sends nothing
  initial begin
    rx_pin = 1'b1;
    frame_errs = 0;
  end

  // A low stop bit lets a scenario provoke a framing fault
  task automatic send_byte(input logic [7:0] b, input logic stop = 1'b1);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_pin <= f[i];
      repeat (BIT_P - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_pin <= 1'b1;
    // After a bad stop bit the line idles a full bit so the receiver resyncs
    if (!stop) repeat (BIT_P) @(posedge clk);
  endtask

  task automatic send_str(input string s);
    foreach (s[i]) send_byte(s[i]);
  endtask

  task automatic send_cmd(input string s);
    send_str(s);
    send_byte(8'h0d);
  endtask

  always begin : rx_proc
    logic [7:0] b;
    @(posedge clk);
    if (tx_drive === 1'b1 && tx_pin === 1'b0) begin
      repeat (BIT_P / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_P) @(posedge clk);
        b[i] = tx_pin;
      end
      repeat (BIT_P) @(posedge clk);
      if (tx_pin !== 1'b1) frame_errs++;
      rx_q.push_back(b);
    end
  end
endmodule // atp_host_model
`default_nettype wire

// >>> tb/ascii_temp_read_command_parser_test.sv
// Testbench for the read-all command parser
`timescale 1ns/1ps
`default_nettype none
module ascii_temp_read_command_parser_test;
  import atp_pkg::*;
  localparam int BIT_P = 16;
  localparam int CHAR_CYC = 10 * BIT_P + 1;
  logic clk, reset_n, default_force, rx_pin, tx_pin, tx_drive;
  atp_bus_req_t bus_req;
  logic [31:0] rd_data, d;
  atp_chan_vals_t chan_vals;
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] exp_q[$];

  atp_parser #(.BIT_CYCLES_P(BIT_P)) i_dut (
    .clk(clk), .reset_n(reset_n), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_drive(tx_drive), .default_force(default_force),
    .bus_req(bus_req), .rd_data(rd_data), .chan_vals(chan_vals));

  atp_host_model #(.BIT_P(BIT_P)) i_host (
    .clk(clk), .tx_pin(tx_pin), .tx_drive(tx_drive), .rx_pin(rx_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Strap must be steady across reset, so it changes with reset held
  task automatic do_reset(input logic force_sw);
    default_force <= force_sw;
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    // Read data stand in the cycle after the strobe; take them as it ends
    @(posedge clk);
    v = rd_data;
  endtask

  task automatic build_data(input logic [7:0] mask);
    int v, ip;
    exp_q = {CH_GT};
    for (int c = 0; c < NUM_CH; c++) begin
      v = $signed(chan_vals[c]);
      if (!mask[c]) begin
        repeat (7) exp_q.push_back(CH_SP);
      end else begin
        exp_q.push_back(v < 0 ? CH_MINUS : CH_PLUS);
        if (v < 0) v = -v;
        ip = v / 100;
        exp_q.push_back(8'(CH_ZERO + ip / 100));
        exp_q.push_back(8'(CH_ZERO + (ip / 10) % 10));
        exp_q.push_back(8'(CH_ZERO + ip % 10));
        exp_q.push_back(CH_DOT);
        exp_q.push_back(8'(CH_ZERO + (v % 100) / 10));
        exp_q.push_back(8'(CH_ZERO + v % 10));
      end
    end
    exp_q.push_back(CH_CR);
  endtask

  // Bounded wait for the whole reply, then the driver must let go
  task automatic expect_reply(input string what);
    int n;
    n = 0;
    while (i_host.rx_q.size() < exp_q.size() && n < CHAR_CYC * 70) begin
      @(posedge clk);
      n++;
    end
    repeat (2 * BIT_P) @(posedge clk);
    chk("reply length", i_host.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(what, i_host.rx_q[i], exp_q[i]);
    chk("tx_drive after reply", tx_drive, 1'b0);
    chk("stop bits", i_host.frame_errs, 0);
    i_host.rx_q.delete();
  endtask

  task automatic expect_silence(input string what);
    repeat (2 * CHAR_CYC) @(posedge clk);
    chk(what, i_host.rx_q.size(), 0);
    chk("tx_drive idle", tx_drive, 1'b0);
    i_host.rx_q.delete();
  endtask

  task automatic t_regs();
    bus_rd(REG_ADDR, d);
    chk("address reg", d, 32'h01);
    @(posedge clk);
    chk("read data after its cycle", rd_data, 32'h0);
    bus_rd(REG_CHEN, d);
    chk("enable reg", d, 32'hff);
    bus_wr(REG_STAT, 32'hffff);
    bus_rd(REG_STAT, d);
    chk("status", d, 32'h0100);
    bus_rd(4'hc, d);
    chk("unmapped", d, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_read_all();
    atp_chan_vals_t cv;
    for (int c = 0; c < NUM_CH; c++) cv[c] = 17'(1816 - 700 * c);
    cv[3] = 17'h0ffff;
    cv[4] = 17'h10000;
    cv[5] = 17'h1ffff;
    chan_vals <= cv;
    i_host.send_cmd("#01");
    bus_rd(REG_STAT, d);
    chk("status busy", d, 32'h0102);
    build_data(8'hff);
    expect_reply("read-all char");
    bus_wr(REG_CHEN, 32'h5a);
    for (int c = 0; c < NUM_CH; c++) cv[c] = 17'(c * 101);
    chan_vals <= cv;
    i_host.send_cmd("#01");
    build_data(8'h5a);
    expect_reply("masked char");
    bus_wr(REG_CHEN, 32'hff);
    $display("test read_all done");
  endtask

  task automatic t_err(input string a);
    string cmds[3];
    cmds = '{{"#", a, "X"}, {"$", a, "2"}, {"%", a, "11000600"}};
    foreach (cmds[i]) begin
      i_host.send_cmd(cmds[i]);
      exp_q = {CH_QM, 8'(a[0]), 8'(a[1]), CH_CR};
      expect_reply("error char");
    end
    $display("test err %s done", a);
  endtask

  task automatic t_silent();
    string cmds[4];
    cmds = '{"#02", "#0a", "#1", "$02"};
    foreach (cmds[i]) begin
      i_host.send_cmd(cmds[i]);
      expect_silence("foreign or malformed");
    end
    i_host.send_str("#01");
    i_host.send_byte(8'h41, 1'b0);
    i_host.send_byte(CH_CR);
    expect_silence("framing error");
    $display("test silent done");
  endtask

  task automatic t_restart();
    i_host.send_str("#0$#01");
    expect_silence("no end of command yet");
    i_host.send_byte(CH_CR);
    build_data(8'hff);
    expect_reply("restarted char");
    $display("test restart done");
  endtask

  task automatic t_addr();
    bus_wr(REG_ADDR, 32'h3a);
    bus_rd(REG_STAT, d);
    chk("status address", d, 32'h3a00);
    t_err("3A");
    i_host.send_cmd("#01");
    expect_silence("old address");
    $display("test addr done");
  endtask

  task automatic t_forced();
    do_reset(1'b1);
    bus_rd(REG_STAT, d);
    chk("forced status", d, 32'h0001);
    bus_rd(REG_ADDR, d);
    chk("address reg kept", d, 32'h01);
    t_err("00");
    i_host.send_cmd("#01");
    expect_silence("stored address ignored");
    do_reset(1'b0);
    $display("test forced done");
  endtask

  initial begin
    reset_n = 1'b0;
    default_force = 1'b0;
    bus_req = '0;
    chan_vals = '0;
    do_reset(1'b0);
    t_regs();
    t_read_all();
    t_err("01");
    t_silent();
    t_restart();
    t_addr();
    t_forced();
    final_report();
  end

  // Whole sequence needs about 55000 cycles at this bit rate
  initial begin
    repeat (95000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule // ascii_temp_read_command_parser_test
`default_nettype wire
